//--- rtl/ppm_regs.vh
`ifndef PPM_REGS_VH
`define PPM_REGS_VH

// Register byte offsets
`define PPM_CAP_HDR_OFS       8'h50
`define PPM_CTRL_STAT_OFS     8'h54

// Capability header fixed pattern and field positions
`define PPM_CAP_HDR_BASE      32'h40000001
`define PPM_CAP_D2_BIT        26
`define PPM_CAP_D1_BIT        25
`define PPM_CAP_DSI_BIT       21
`define PPM_CAP_CLK_BIT       19
`define PPM_CAP_VER_LO        16

// Control/status field positions
`define PPM_CS_WAKE_FLAG_BIT  15
`define PPM_CS_WAKE_EN_BIT    8
`define PPM_CS_KEEP_CTX_BIT   3

// Power state encodings
`define PPM_PS_D0             2'h0
`define PPM_PS_D1             2'h1
`define PPM_PS_D2             2'h2
`define PPM_PS_D3HOT          2'h3

// Length of the internal soft reset pulse, in clock cycles
`define PPM_SOFT_RST_CYCLES   4'h4

`endif

//--- rtl/ppm_pci_pm_cap.v
`timescale 1ns/10ps
`include "ppm_regs.vh"

module ppm_pci_pm_cap (
    // Clock and power-up reset
    input  wire        mclk_in,
    input  wire        reset_n_in,
    // Hardware (system/bus segment) reset, same clock domain
    input  wire        hw_reset_n_in,
    // Register port
    input  wire [7:0]  addr_in,
    input  wire [31:0] wdata_in,
    input  wire        wr_in,
    input  wire        rd_in,
    output reg  [31:0] rdata_out,
    // EEPROM configuration, sampled while the load strobe is high
    input  wire        ee_load_in,
    input  wire        ee_d2_sup_in,
    input  wire        ee_d1_sup_in,
    input  wire        ee_dsi_in,
    input  wire        wake_needs_clock_cfg_in,
    input  wire [2:0]  ee_pm_ver_in,
    // Power-management event from the wake logic
    input  wire        pm_event_in,
    // Wake request pin, open drain, active low on the wire
    output reg         wake_request_pin_out,
    output reg         wake_request_pin_oe_out,
    // Power state and context control
    output reg  [1:0]  power_state_out,
    output reg         soft_reset_out,
    output reg         keep_ctx_out
);

    // Header fields loaded from EEPROM
    reg        cap_d2;
    reg        cap_d1;
    reg        cap_dsi;
    reg        cap_clk;
    reg [2:0]  cap_ver;
    // Control/status state
    reg        wake_event_flag;
    reg        wake_signal_enable;
    reg        keep_ctx;
    reg [1:0]  pwr_state;
    reg [3:0]  srst_cnt;
    // Next values
    reg        next_wake_event_flag;
    reg        next_wake_signal_enable;
    reg        next_keep_ctx;
    reg [1:0]  next_pwr_state;
    reg [3:0]  next_srst_cnt;

    // Read data before it is registered
    reg [31:0] next_rdata;

    // Register decodes; the header has no write decode on purpose
    wire       wr_cs;
    wire       rd_cap;
    wire       rd_cs;
    wire       sw_leave_d3;

    assign wr_cs  = wr_in && (addr_in == `PPM_CTRL_STAT_OFS);
    assign rd_cap = rd_in && (addr_in == `PPM_CAP_HDR_OFS);
    assign rd_cs  = rd_in && (addr_in == `PPM_CTRL_STAT_OFS);
    // Software request from D3hot back to D0
    assign sw_leave_d3 = wr_cs && (pwr_state == `PPM_PS_D3HOT) &&
                         (wdata_in[1:0] == `PPM_PS_D0);

    // Assemble the header word from fixed pattern and loaded fields
    function [31:0] cap_word;
        input       d2;
        input       d1;
        input       dsi;
        input       clk;
        input [2:0] ver;
        begin
            cap_word = `PPM_CAP_HDR_BASE;
            cap_word[`PPM_CAP_D2_BIT]  = d2;
            cap_word[`PPM_CAP_D1_BIT]  = d1;
            cap_word[`PPM_CAP_DSI_BIT] = dsi;
            cap_word[`PPM_CAP_CLK_BIT] = clk;
            cap_word[`PPM_CAP_VER_LO +: 3] = ver;
        end
    endfunction

    // Assemble the control/status word; reserved bits stay zero
    function [31:0] cs_word;
        input       flag;
        input       en;
        input       kc;
        input [1:0] ps;
        begin
            cs_word = 32'h00000000;
            cs_word[`PPM_CS_WAKE_FLAG_BIT] = flag;
            cs_word[`PPM_CS_WAKE_EN_BIT]   = en;
            cs_word[`PPM_CS_KEEP_CTX_BIT]  = kc;
            cs_word[1:0] = ps;
        end
    endfunction

    // EEPROM load of the support bits; the header has no write path
    always @(posedge mclk_in) begin
        if (!reset_n_in) begin
            cap_d2  <= 1'b0;
            cap_d1  <= 1'b0;
            cap_dsi <= 1'b0;
        end else if (ee_load_in) begin
            cap_d2  <= ee_d2_sup_in;
            cap_d1  <= ee_d1_sup_in;
            cap_dsi <= ee_dsi_in;
        end
    end

    // EEPROM load of the wake-needs-clock bit
    always @(posedge mclk_in) begin
        if (!reset_n_in)
            cap_clk <= 1'b0;
        else if (ee_load_in)
            cap_clk <= wake_needs_clock_cfg_in;
    end

    // EEPROM load of the version field
    always @(posedge mclk_in) begin
        if (!reset_n_in)
            cap_ver <= 3'h0;
        else if (ee_load_in)
            cap_ver <= ee_pm_ver_in;
    end

    // Next wake flag; the event beats a same-cycle clear
    always @* begin
        next_wake_event_flag = wake_event_flag;
        if (wr_cs && wdata_in[`PPM_CS_WAKE_FLAG_BIT])
            next_wake_event_flag = 1'b0;
        if (pm_event_in)
            next_wake_event_flag = 1'b1;
    end

    // Next wake enable; system reset does not reach it
    always @* begin
        next_wake_signal_enable = wake_signal_enable;
        if (wr_cs)
            next_wake_signal_enable = wdata_in[`PPM_CS_WAKE_EN_BIT];
    end

    // Next keep-context; system reset drops it so D0 is uninitialized
    always @* begin
        next_keep_ctx = keep_ctx;
        if (wr_cs)
            next_keep_ctx = wdata_in[`PPM_CS_KEEP_CTX_BIT];
        if (!hw_reset_n_in)
            next_keep_ctx = 1'b0;
    end

    // Next power state; system reset forces D0
    always @* begin
        next_pwr_state = pwr_state;
        if (wr_cs)
            next_pwr_state = wdata_in[1:0];
        if (!hw_reset_n_in)
            next_pwr_state = `PPM_PS_D0;
    end

    // Soft reset counter; uses the stored keep-context, not the written one
    always @* begin
        next_srst_cnt = srst_cnt;
        if (srst_cnt != 4'h0)
            next_srst_cnt = srst_cnt - 4'h1;
        if (sw_leave_d3 && !keep_ctx)
            next_srst_cnt = `PPM_SOFT_RST_CYCLES;
        // Keep-context set: no new pulse is started
        if (!hw_reset_n_in)
            next_srst_cnt = 4'h0;
    end

    // Wake flag; only power-up reset clears it here
    always @(posedge mclk_in) begin
        if (!reset_n_in)
            wake_event_flag <= 1'b0;
        else
            wake_event_flag <= next_wake_event_flag;
    end

    // Wake enable; power-up reset only
    always @(posedge mclk_in) begin
        if (!reset_n_in)
            wake_signal_enable <= 1'b0;
        else
            wake_signal_enable <= next_wake_signal_enable;
    end

    // Keep-context bit
    always @(posedge mclk_in) begin
        if (!reset_n_in)
            keep_ctx <= 1'b0;
        else
            keep_ctx <= next_keep_ctx;
    end

    // Power state, D0 after power-up
    always @(posedge mclk_in) begin
        if (!reset_n_in)
            pwr_state <= `PPM_PS_D0;
        else
            pwr_state <= next_pwr_state;
    end

    // Soft reset counter
    always @(posedge mclk_in) begin
        if (!reset_n_in)
            srst_cnt <= 4'h0;
        else
            srst_cnt <= next_srst_cnt;
    end

    // Open drain: data held low, only the enable moves
    always @(posedge mclk_in) begin
        wake_request_pin_out <= 1'b0;
    end

    // Pin enable follows next values, saving a cycle of wake latency
    always @(posedge mclk_in) begin
        if (!reset_n_in)
            wake_request_pin_oe_out <= 1'b0;
        else
            wake_request_pin_oe_out <= next_wake_event_flag &&
                                       next_wake_signal_enable;
    end

    // Power state copy for the rest of the chip
    always @(posedge mclk_in) begin
        if (!reset_n_in)
            power_state_out <= `PPM_PS_D0;
        else
            power_state_out <= next_pwr_state;
    end

    // Soft reset pulse, high while the counter runs
    always @(posedge mclk_in) begin
        if (!reset_n_in)
            soft_reset_out <= 1'b0;
        else
            soft_reset_out <= (next_srst_cnt != 4'h0);
    end

    // Keep-context copy
    always @(posedge mclk_in) begin
        if (!reset_n_in)
            keep_ctx_out <= 1'b0;
        else
            keep_ctx_out <= next_keep_ctx;
    end

    // Read mux; unmapped addresses and idle cycles read zero
    always @* begin
        next_rdata = 32'h00000000;
        if (rd_cap)
            next_rdata = cap_word(cap_d2, cap_d1, cap_dsi, cap_clk, cap_ver);
        else if (rd_cs)
            next_rdata = cs_word(wake_event_flag, wake_signal_enable,
                                 keep_ctx, pwr_state);
    end

    // Read data stands only in the cycle after the strobe
    always @(posedge mclk_in) begin
        if (!reset_n_in)
            rdata_out <= 32'h00000000;
        else
            rdata_out <= next_rdata;
    end

endmodule

//--- sim/ppm_wake_line.sv
`timescale 1ns/10ps
module ppm_wake_line (
    // Open-drain pin as seen by the host
    input  wire drv_in,
    input  wire oe_in,
    output wire wake_n_out
);
    // Board pull-up holds the line high once the device lets go
    assign wake_n_out = oe_in ? drv_in : 1'b1;
endmodule

//--- sim/ppm_pci_pm_cap_props.sv
`timescale 1ns/10ps
module ppm_pci_pm_cap_props (
    input wire        mclk_in,
    input wire        reset_n_in,
    input wire        hw_reset_n_in,
    input wire [7:0]  addr_in,
    input wire [31:0] wdata_in,
    input wire        wr_in,
    input wire        rd_in,
    input wire [31:0] rdata_out,
    input wire        pm_event_in,
    input wire        wake_request_pin_out,
    input wire        wake_request_pin_oe_out,
    input wire [1:0]  power_state_out,
    input wire        soft_reset_out,
    input wire        keep_ctx_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!reset_n_in);
    // Register access decodes
    sequence rd_cs; rd_in && addr_in == 8'h54; endsequence
    sequence go_d0; wr_in && addr_in == 8'h54 && wdata_in[1:0] == 2'h0
        && power_state_out == 2'h3 && hw_reset_n_in; endsequence
    a_rdata_idle: assert property (!rd_in |=> rdata_out == 32'h0) else $error("rdata not idle");
    a_hdr_fixed: assert property (rd_in && addr_in == 8'h50 |=> rdata_out[15:0] == 16'h0001
        && rdata_out[31:27] == 5'h08 && rdata_out[24:22] == 3'h0) else $error("bad header");
    a_cs_rsvd: assert property (rd_cs |=> rdata_out[31:16] == 16'h0 && rdata_out[14:9] == 6'h0
        && rdata_out[7:4] == 4'h0 && !rdata_out[2]) else $error("reserved bits set");
    a_state_read: assert property (rd_cs |=> rdata_out[3:0] ==
        {$past(keep_ctx_out), 1'b0, $past(power_state_out)}) else $error("state mismatch");
    a_event_flag: assert property (pm_event_in ##1 rd_cs |=> rdata_out[15]) else $error("flag lost");
    a_pin_follows: assert property (rd_cs |=> (rdata_out[15] && rdata_out[8]) ==
        $past(wake_request_pin_oe_out)) else $error("pin mismatch");
    a_flag_clear: assert property (wr_in && addr_in == 8'h54 && wdata_in[15] && !pm_event_in
        |=> !wake_request_pin_oe_out) else $error("pin not released");
    a_pin_cause: assert property ($rose(wake_request_pin_oe_out) |-> $past(pm_event_in)
        || $past(wr_in)) else $error("pin without cause");
    a_hw_keep: assert property (!hw_reset_n_in && !pm_event_in && !wr_in
        |=> $stable(wake_request_pin_oe_out)) else $error("wake changed");
    a_hw_state: assert property (!hw_reset_n_in |=> power_state_out == 2'h0 && !keep_ctx_out
        && !soft_reset_out) else $error("hw reset state");
    a_soft_pulse: assert property (go_d0 and !keep_ctx_out |=> soft_reset_out[*4]
        ##1 !soft_reset_out) else $error("soft pulse");
    a_keep_ctx: assert property (go_d0 and keep_ctx_out && !soft_reset_out
        |=> !soft_reset_out) else $error("soft reset");
endmodule
bind ppm_pci_pm_cap ppm_pci_pm_cap_props ppm_pci_pm_cap_props_i (.*);

//--- sim/ppm_pci_pm_cap_tb.sv
`timescale 1ns/10ps
module ppm_pci_pm_cap_tb;
    reg mclk_in = 0, reset_n_in = 0, hw_reset_n_in = 1, wr_in = 0, rd_in = 0;
    reg ee_load_in = 0, pm_event_in = 0;
    reg [4:0] ee_in = 5'h0;
    reg [2:0] ver_in = 3'h0;
    reg [7:0] addr_in = 8'h0;
    reg [31:0] wdata_in = 32'h0, seed = 32'h429e, d;
    wire [31:0] rdata_out;
    wire [1:0] ps;
    wire pin, oe, srst, kc, wake_n;
    integer fails = 0, samples_checked = 0, cyc = 0, i;
    ppm_pci_pm_cap ppm_pci_pm_cap_i (.mclk_in(mclk_in), .reset_n_in(reset_n_in),
        .hw_reset_n_in(hw_reset_n_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
        .rd_in(rd_in), .rdata_out(rdata_out), .ee_load_in(ee_load_in), .ee_d2_sup_in(ee_in[4]),
        .ee_d1_sup_in(ee_in[3]), .ee_dsi_in(ee_in[2]), .wake_needs_clock_cfg_in(ee_in[1]),
        .ee_pm_ver_in(ver_in), .pm_event_in(pm_event_in), .wake_request_pin_out(pin),
        .wake_request_pin_oe_out(oe), .power_state_out(ps), .soft_reset_out(srst),
        .keep_ctx_out(kc));
    ppm_wake_line ppm_wake_line_i (.drv_in(pin), .oe_in(oe), .wake_n_out(wake_n));
    initial forever #4 mclk_in = ~mclk_in;
    // Expected header from loaded configuration
    function [31:0] exp_hdr(input [4:0] e, input [2:0] v);
        exp_hdr = 32'h40000001 | {e[4:3], 3'h0, e[2], 1'b0, e[1], v, 16'h0};
    endfunction
    task end_of_test;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task chk(input string n, input [31:0] e, input [31:0] s);
        samples_checked++;
        if (s !== e) begin
            $display("[FAIL] %s expected %h seen %h", n, e, s);
            fails++;
        end
    endtask
    task wr(input [7:0] a, input [31:0] v);
        @(posedge mclk_in) {addr_in, wdata_in, wr_in} <= {a, v, 1'b1};
        @(posedge mclk_in) wr_in <= 1'b0;
        #1;
    endtask
    task rd(input [7:0] a, input [31:0] e);
        @(posedge mclk_in) {addr_in, rd_in} <= {a, 1'b1};
        @(posedge mclk_in) rd_in <= 1'b0;
        #1 chk("rdata", e, rdata_out);
    endtask
    task pulse_ev;
        @(posedge mclk_in) pm_event_in <= 1'b1;
        @(posedge mclk_in) pm_event_in <= 1'b0;
        #1;
    endtask
    // Cuts a hang short well beyond the expected run
    always @(posedge mclk_in) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fails++;
            end_of_test;
        end
    end
    initial begin
        repeat (2) @(posedge mclk_in);
        reset_n_in <= 1'b1;
        rd(8'h50, 32'h40000001);
        rd(8'h54, 32'h0);
        rd(8'h60, 32'h0);
        for (i = 0; i < 6; i++) begin
            d = $random(seed);
            @(posedge mclk_in) {ee_in, ver_in, ee_load_in} <= {d[4:0], d[7:5], 1'b1};
            @(posedge mclk_in) ee_load_in <= 1'b0;
            wr(8'h50, ~d);
            rd(8'h50, exp_hdr(d[4:0], d[7:5]));
            wr(8'h54, d & 32'hffff7fff);
            rd(8'h54, d & 32'h0000010b);
        end
        $display("header and field tests done");
        for (i = 0; i < 4; i++) wr(8'h54, i);
        rd(8'h54, 32'h3);
        wr(8'h54, 32'h0);
        chk("soft", 1, srst);
        wr(8'h54, 32'hb);
        chk("ps", 3, ps);
        chk("kc", 1, kc);
        wr(8'h54, 32'h8);
        chk("soft", 0, srst);
        $display("state tests done");
        wr(8'h54, 32'h0);
        pulse_ev;
        chk("oe", 0, oe);
        rd(8'h54, 32'h8000);
        wr(8'h54, 32'h10b);
        chk("wake_n", 0, wake_n);
        @(posedge mclk_in) hw_reset_n_in <= 1'b0;
        @(posedge mclk_in) hw_reset_n_in <= 1'b1;
        rd(8'h54, 32'h8100);
        wr(8'h54, 32'h8100);
        chk("wake_n", 1, wake_n);
        $display("wake tests done");
        end_of_test;
    end
endmodule
